// file: smc_map.vh
`ifndef SMC_MAP_VH
`define SMC_MAP_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define SMC_A_CLOCK_CONFIG   8'h00
`define SMC_A_AUX_CTRL       8'h04
`define SMC_A_AUX_CTRL_TWO   8'h08
`define SMC_A_EEPROM_CTRL    8'h0C
`define SMC_A_CLK_CTRL_ZERO  8'h10
`define SMC_A_CLK_RELOAD     8'h14
`define SMC_A_TOGGLE_CTRL    8'h18
`define SMC_A_KEYPAD_FLAG    8'h1C
`define SMC_A_PIN_MODE_LOW   8'h20
`define SMC_A_PIN_MODE_HIGH  8'h24
`define SMC_A_PIN_MODE_P4    8'h28
`define SMC_A_STATUS         8'h2C
`define SMC_A_TIMER_CTRL     8'h30
// ----------------------------------------
// field positions
// ----------------------------------------
`define SMC_TPS_HI           7
`define SMC_TPS_LO           4
`define SMC_ALS_OFF_BIT      0
`define SMC_XDATA_EN_BIT     1
`define SMC_WS_HI            6
`define SMC_WS_LO            5
`define SMC_STK_XRAM_BIT     4
`define SMC_FLASH_API_BIT    5
`define SMC_EEPROM_EN_BIT    1
`define SMC_DBL_SPEED_BIT    0
`define SMC_T0_TOG_BIT       0
`define SMC_T1_TOG_BIT       1
`define SMC_LOCK4_BIT        2
`define SMC_T2_BYPASS_BIT    0
// ----------------------------------------
// reset values, modes, limits and response codes
// ----------------------------------------
`define SMC_TPS_COMPAT       4'h5
`define SMC_TPS_FAST         4'h0
`define SMC_RLD_DEFAULT      8'hFF
`define SMC_MODE_QUASI       2'b00
`define SMC_MODE_PUSHPULL    2'b01
`define SMC_MODE_INPUT       2'b10
`define SMC_MODE_OPENDRAIN   2'b11
`define SMC_FETCH_COMPAT     2'h2
`define SMC_EXT_LOW_LIMIT    16'h1FFF
`define SMC_RESP_OKAY        2'b00
`define SMC_RESP_SLVERR      2'b10
`endif

// file: smc_prescaler.v
`include "smc_map.vh"
module smc_prescaler (
   input  wire       i_clk_sys,
   input  wire       i_nrst,
   input  wire [3:0] i_ratio,
   output reg        o_tick
);
   reg [3:0] cnt_reg;
   // divide by ratio+1: 0 gives system clock, 15 gives one sixteenth
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         cnt_reg <= 4'h0;
         o_tick  <= 1'b0;
      end else if (cnt_reg >= i_ratio) begin
         cnt_reg <= 4'h0;
         o_tick  <= 1'b1;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
         o_tick  <= 1'b0;
      end
   end
endmodule

// file: smc_pin_sampler.v
`include "smc_map.vh"
module smc_pin_sampler #(
   parameter W = 6
) (
   input  wire         i_clk_sys,
   input  wire         i_nrst,
   input  wire         i_fast,
   input  wire         i_tick,
   input  wire [W-1:0] i_pins,
   output reg  [W-1:0] o_pins
);
   reg [W-1:0] s1_reg;
   reg [W-1:0] s2_reg;
   // two stages before use, pins are asynchronous
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s1_reg <= {W{1'b0}};
         s2_reg <= {W{1'b0}};
         o_pins <= {W{1'b0}};
      end else begin
         s1_reg <= i_pins;
         s2_reg <= s1_reg;
         if (i_fast || i_tick)
            o_pins <= s2_reg;
      end
   end
endmodule

// file: smc_system_config.v
`include "smc_map.vh"
module smc_system_config #(
   parameter NPORT = 4
) (
   input  wire        i_clk_sys,
   input  wire        i_nrst,
   input  wire        i_fuse_compat,
   input  wire        i_fuse_tristate,
   input  wire        i_fuse_dbl_speed,
   input  wire        i_fuse_xdata,
   input  wire        i_reset_sense_select,
   input  wire        i_reset_pin,
   input  wire [5:0]  i_ext_pins,
   input  wire        i_timer0_ovf,
   input  wire        i_timer1_ovf,
   input  wire [7:0]  i_keypad_events,
   input  wire        i_fetch_req,
   input  wire [15:0] i_fetch_addr,
   input  wire        i_fetch_external,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output reg         o_sys_reset,
   output reg         o_fast_mode,
   output reg  [3:0]  o_timer_prescale_field,
   output reg         o_timer_tick,
   output reg         o_timer2_tick,
   output reg  [5:0]  o_sampled_pins,
   output reg         o_fetch_strobe,
   output reg  [2:0]  o_exec_unit,
   output reg         o_fetch_allowed,
   output reg  [7:0]  o_clock_reload_divider,
   output reg         o_double_speed_select,
   output reg         o_address_latch_strobe_off,
   output reg         o_onchip_xdata_enable,
   output reg  [1:0]  o_xmem_wait_states,
   output reg         o_stack_in_extra_ram,
   output reg         o_flash_api_access,
   output reg         o_eeprom_access_enable,
   output reg  [2*8*NPORT-1:0] o_pin_modes,
   output reg  [15:0] o_port4_modes,
   output reg         o_timer0_count_pin,
   output reg         o_timer0_count_pin_oe,
   output reg         o_timer1_count_pin,
   output reg         o_timer1_count_pin_oe,
   output reg  [7:0]  o_keypad_flag_reg
);
   // ----------------------------------------
   // reset pin synchroniser and polarity
   // ----------------------------------------
   reg [1:0] rst_sync_reg;
   reg [1:0] pol_sync_reg;
   wire      rst_req = (rst_sync_reg[1] == pol_sync_reg[1]);
   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         rst_sync_reg <= 2'b00;
         pol_sync_reg <= 2'b11;
         o_sys_reset  <= 1'b0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], i_reset_pin};
         pol_sync_reg <= {pol_sync_reg[0], i_reset_sense_select};
         o_sys_reset  <= rst_req; // pulse length is the driver's duty
      end
   end
   wire any_rst = !i_nrst || o_sys_reset;

   // ----------------------------------------
   // fuse capture
   // ----------------------------------------
   // fuses latched in reset so a moving fuse input cannot glitch the mode
   reg fuse_tri_reg;
   always @(posedge i_clk_sys) begin
      if (any_rst) begin
         o_fast_mode  <= !i_fuse_compat;
         fuse_tri_reg <= i_fuse_tristate;
      end
   end

   function [1:0] def_mode;
      input integer port;
      begin
         if (i_fuse_tristate)
            def_mode = `SMC_MODE_INPUT;
         else if (port == 0)
            def_mode = `SMC_MODE_OPENDRAIN;
         else
            def_mode = `SMC_MODE_QUASI;
      end
   endfunction

   // ----------------------------------------
   // axi4-lite slave
   // ----------------------------------------
   reg [7:0]  awaddr_reg;
   reg [31:0] wdata_reg;
   reg [3:0]  wstrb_reg;
   reg        aw_have_reg;
   reg        w_have_reg;
   reg [7:0]  t2_ctrl_reg;
   reg [7:0]  toggle_ctrl_reg;
   wire       wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;
   wire       wr_b0 = wr_go && wstrb_reg[0];
   wire       wr_b1 = wr_go && wstrb_reg[1];
   wire [7:0] wb0   = wdata_reg[7:0];

   function hit;
      input [7:0] a;
      input [7:0] c;
      begin
         hit = (a[7:2] == c[7:2]);
      end
   endfunction

   function mapped;
      input [7:0] a;
      begin
         mapped = (a[7:2] <= `SMC_A_TIMER_CTRL >> 2);
      end
   endfunction

   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
         aw_have_reg   <= 1'b0;
         w_have_reg    <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `SMC_RESP_OKAY;
         awaddr_reg    <= 8'h00;
         wdata_reg     <= 32'h0000_0000;
         wstrb_reg     <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            awaddr_reg    <= s_axi_awaddr;
            aw_have_reg   <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
            w_have_reg   <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= mapped(awaddr_reg) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
            aw_have_reg  <= 1'b0;
            w_have_reg   <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   integer k;
   always @(posedge i_clk_sys) begin
      if (any_rst) begin
         o_timer_prescale_field     <= i_fuse_compat ? `SMC_TPS_COMPAT : `SMC_TPS_FAST;
         o_clock_reload_divider     <= `SMC_RLD_DEFAULT;
         o_double_speed_select      <= i_fuse_dbl_speed || !i_fuse_compat;
         o_address_latch_strobe_off <= 1'b0;
         o_onchip_xdata_enable      <= i_fuse_xdata;
         o_xmem_wait_states         <= 2'b00;
         o_stack_in_extra_ram       <= 1'b0;
         o_flash_api_access         <= 1'b0;
         o_eeprom_access_enable     <= 1'b0;
         toggle_ctrl_reg            <= 8'h00;
         t2_ctrl_reg                <= 8'h00;
         o_port4_modes              <= 16'h0000; // port 4 resets to quasi whatever the tristate fuse
         for (k = 0; k < 8*NPORT; k = k + 1)
            o_pin_modes[2*k +: 2] <= def_mode(k / 8);
      end else begin
         if (wr_b0 && hit(awaddr_reg, `SMC_A_CLOCK_CONFIG))
            o_timer_prescale_field <= wb0[`SMC_TPS_HI:`SMC_TPS_LO];
         if (wr_b0 && hit(awaddr_reg, `SMC_A_AUX_CTRL)) begin
            o_address_latch_strobe_off <= wb0[`SMC_ALS_OFF_BIT];
            o_onchip_xdata_enable      <= wb0[`SMC_XDATA_EN_BIT];
            o_xmem_wait_states         <= wb0[`SMC_WS_HI:`SMC_WS_LO];
         end
         if (wr_b0 && hit(awaddr_reg, `SMC_A_AUX_CTRL_TWO)) begin
            o_stack_in_extra_ram <= wb0[`SMC_STK_XRAM_BIT];
            o_flash_api_access   <= wb0[`SMC_FLASH_API_BIT];
         end
         if (wr_b0 && hit(awaddr_reg, `SMC_A_EEPROM_CTRL))
            o_eeprom_access_enable <= wb0[`SMC_EEPROM_EN_BIT];
         if (wr_b0 && hit(awaddr_reg, `SMC_A_CLK_CTRL_ZERO))
            o_double_speed_select <= wb0[`SMC_DBL_SPEED_BIT];
         if (wr_b0 && hit(awaddr_reg, `SMC_A_CLK_RELOAD))
            o_clock_reload_divider <= wb0;
         if (wr_b0 && hit(awaddr_reg, `SMC_A_TOGGLE_CTRL))
            toggle_ctrl_reg <= wb0;
         if (wr_b0 && hit(awaddr_reg, `SMC_A_TIMER_CTRL))
            t2_ctrl_reg <= wb0;
         // two mode bits per pin in separate low and high planes
         for (k = 0; k < 8*NPORT; k = k + 1) begin
            if (wstrb_reg[k/8] && wr_go && hit(awaddr_reg, `SMC_A_PIN_MODE_LOW))
               o_pin_modes[2*k] <= wdata_reg[k];
            if (wstrb_reg[k/8] && wr_go && hit(awaddr_reg, `SMC_A_PIN_MODE_HIGH))
               o_pin_modes[2*k+1] <= wdata_reg[k];
         end
         if (wr_b0 && hit(awaddr_reg, `SMC_A_PIN_MODE_P4))
            o_port4_modes[7:0] <= wb0;
         if (wr_b1 && hit(awaddr_reg, `SMC_A_PIN_MODE_P4))
            o_port4_modes[15:8] <= wdata_reg[15:8];
      end
   end

   // ----------------------------------------
   // keypad flags
   // ----------------------------------------
   // reads leave flags alone; writing one clears that bit, new event wins
   wire [7:0] kb_clr = (wr_b0 && hit(awaddr_reg, `SMC_A_KEYPAD_FLAG)) ? wb0 : 8'h00;
   always @(posedge i_clk_sys) begin
      if (any_rst)
         o_keypad_flag_reg <= 8'h00;
      else
         o_keypad_flag_reg <= (o_keypad_flag_reg & ~kb_clr) | i_keypad_events;
   end

   // ----------------------------------------
   // read channel
   // ----------------------------------------
   reg [31:0] rd_mux;
   integer j;
   always @* begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr[7:2])
         `SMC_A_CLOCK_CONFIG  >> 2: rd_mux[7:4] = o_timer_prescale_field;
         `SMC_A_AUX_CTRL      >> 2: rd_mux[7:0] = {1'b0, o_xmem_wait_states, 3'b000,
                                                   o_onchip_xdata_enable, o_address_latch_strobe_off};
         `SMC_A_AUX_CTRL_TWO  >> 2: rd_mux[7:0] = {2'b00, o_flash_api_access, o_stack_in_extra_ram, 4'h0};
         `SMC_A_EEPROM_CTRL   >> 2: rd_mux[7:0] = {6'h00, o_eeprom_access_enable, 1'b0};
         `SMC_A_CLK_CTRL_ZERO >> 2: rd_mux[0]   = o_double_speed_select;
         `SMC_A_CLK_RELOAD    >> 2: rd_mux[7:0] = o_clock_reload_divider;
         `SMC_A_TOGGLE_CTRL   >> 2: rd_mux[7:0] = toggle_ctrl_reg;
         `SMC_A_KEYPAD_FLAG   >> 2: rd_mux[7:0] = o_keypad_flag_reg;
         `SMC_A_PIN_MODE_LOW  >> 2: for (j = 0; j < 8*NPORT; j = j + 1) rd_mux[j] = o_pin_modes[2*j];
         `SMC_A_PIN_MODE_HIGH >> 2: for (j = 0; j < 8*NPORT; j = j + 1) rd_mux[j] = o_pin_modes[2*j+1];
         `SMC_A_PIN_MODE_P4   >> 2: rd_mux[15:0] = o_port4_modes;
         `SMC_A_STATUS        >> 2: rd_mux[1:0] = {fuse_tri_reg, o_fast_mode};
         `SMC_A_TIMER_CTRL    >> 2: rd_mux[7:0] = t2_ctrl_reg;
         default:                   rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge i_clk_sys) begin
      if (!i_nrst) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= mapped(s_axi_araddr) ? `SMC_RESP_OKAY : `SMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

   // ----------------------------------------
   // prescaler, pin sampling, timer 2 bypass
   // ----------------------------------------
   wire pre_tick;
   smc_prescaler u_pre (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst && !o_sys_reset),
      .i_ratio   (o_timer_prescale_field),
      .o_tick    (pre_tick)
   );
   wire [5:0] samp;
   smc_pin_sampler #(.W(6)) u_samp (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (i_nrst),
      .i_fast    (o_fast_mode),
      .i_tick    (pre_tick),
      .i_pins    (i_ext_pins),
      .o_pins    (samp)
   );
   always @(posedge i_clk_sys) begin
      o_timer_tick   <= pre_tick && !any_rst;
      o_timer2_tick  <= t2_ctrl_reg[`SMC_T2_BYPASS_BIT] ? !any_rst : (pre_tick && !any_rst);
      o_sampled_pins <= any_rst ? 6'h00 : samp;
   end

   // ----------------------------------------
   // timer count pin toggling
   // ----------------------------------------
   always @(posedge i_clk_sys) begin
      if (any_rst) begin
         o_timer0_count_pin    <= 1'b0;
         o_timer1_count_pin    <= 1'b0;
         o_timer0_count_pin_oe <= 1'b0;
         o_timer1_count_pin_oe <= 1'b0;
      end else begin
         o_timer0_count_pin_oe <= toggle_ctrl_reg[`SMC_T0_TOG_BIT];
         o_timer1_count_pin_oe <= toggle_ctrl_reg[`SMC_T1_TOG_BIT];
         if (i_timer0_ovf && toggle_ctrl_reg[`SMC_T0_TOG_BIT])
            o_timer0_count_pin <= !o_timer0_count_pin;
         if (i_timer1_ovf && toggle_ctrl_reg[`SMC_T1_TOG_BIT])
            o_timer1_count_pin <= !o_timer1_count_pin;
      end
   end

   // ----------------------------------------
   // fetch pacing and external fetch guard
   // ----------------------------------------
   // unit is 6 in compat, 1 in fast; fetch slot counts 3 clocks in compat, 1 in fast
   reg [1:0] fetch_cnt_reg;
   always @(posedge i_clk_sys) begin
      if (any_rst) begin
         fetch_cnt_reg   <= 2'b00;
         o_fetch_strobe  <= 1'b0;
         o_fetch_allowed <= 1'b0;
         o_exec_unit     <= 3'h0;
      end else begin
         o_exec_unit <= o_fast_mode ? 3'h1 : 3'h6;
         if (o_fast_mode || fetch_cnt_reg == `SMC_FETCH_COMPAT) begin
            fetch_cnt_reg  <= 2'b00;
            o_fetch_strobe <= i_fetch_req;
         end else begin
            fetch_cnt_reg  <= fetch_cnt_reg + 2'b01;
            o_fetch_strobe <= 1'b0;
         end
         o_fetch_allowed <= !i_fetch_external ||
            (i_fetch_addr > `SMC_EXT_LOW_LIMIT && !toggle_ctrl_reg[`SMC_LOCK4_BIT]);
      end
   end
endmodule

// file: smc_system_config_sva.sv
module smc_sc_chk #(
   parameter NPORT = 4
) (
   input logic                 i_clk_sys,
   input logic                 i_nrst,
   input logic                 i_fuse_tristate,
   input logic                 i_reset_sense_select,
   input logic                 i_reset_pin,
   input logic                 i_fetch_req,
   input logic [15:0]          i_fetch_addr,
   input logic                 i_fetch_external,
   input logic                 s_axi_bvalid,
   input logic                 s_axi_bready,
   input logic                 o_sys_reset,
   input logic                 o_fast_mode,
   input logic [3:0]           o_timer_prescale_field,
   input logic                 o_timer_tick,
   input logic                 o_fetch_strobe,
   input logic [2:0]           o_exec_unit,
   input logic                 o_fetch_allowed,
   input logic [7:0]           o_clock_reload_divider,
   input logic [2*8*NPORT-1:0] o_pin_modes,
   input logic [7:0]           o_keypad_flag_reg
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_nrst);
   // ----
   // tick spacing, measured only once the field has settled
   // ----
   logic [4:0] gap_reg;
   logic [3:0] fld_reg;
   logic       seen_reg;
   always_ff @(posedge i_clk_sys) begin
      fld_reg <= o_timer_prescale_field;
      if (!i_nrst || o_sys_reset || o_timer_prescale_field != fld_reg) begin
         seen_reg <= 1'b0;
      end else if (o_timer_tick) begin
         seen_reg <= 1'b1;
      end
      if (o_timer_tick) begin
         gap_reg <= 5'h01;
      end else if (gap_reg != 5'h1f) begin
         gap_reg <= gap_reg + 5'h01;
      end
   end
   sequence quiet_two;
      !o_fetch_strobe [*2];
   endsequence
   sequence sense_on;
      (i_reset_pin == i_reset_sense_select) [*4];
   endsequence
   sequence sense_off;
      (i_reset_pin != i_reset_sense_select) [*4];
   endsequence
   // ----
   // assertions
   // ----
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   fetch_pace_a: assert property (!o_fast_mode && o_fetch_strobe |=> quiet_two)
      else $error("fetch strobe too close");
   exec_time_a: assert property (o_fetch_strobe |-> o_exec_unit == (o_fast_mode ? 3'h1 : 3'h6))
      else $error("execution unit wrong");
   reset_dflt_a: assert property (
      $rose(i_nrst) |-> o_timer_prescale_field == (o_fast_mode ? 4'h0 : 4'h5) && o_clock_reload_divider == 8'hff)
      else $error("clock defaults wrong");
   port_dflt_a: assert property (
      $rose(i_nrst) |-> o_pin_modes[15:0] == (i_fuse_tristate ? 16'haaaa : 16'hffff))
      else $error("port 0 default mode wrong");
   tick_gap_a: assert property (
      o_timer_tick && seen_reg && o_timer_prescale_field == fld_reg |-> gap_reg == o_timer_prescale_field + 5'h01)
      else $error("timer tick spacing wrong");
   ext_fetch_a: assert property (
      i_fetch_req && i_fetch_external && i_fetch_addr <= 16'h1fff |=> !o_fetch_allowed)
      else $error("low external fetch allowed");
   flag_keep_a: assert property (
      |($past(o_keypad_flag_reg) & ~o_keypad_flag_reg) |-> $rose(s_axi_bvalid) || o_sys_reset || $past(o_sys_reset))
      else $error("keypad flag lost without write");
   sense_on_a: assert property (sense_on |-> o_sys_reset)
      else $error("pin reset not seen");
   sense_off_a: assert property (sense_off |-> !o_sys_reset)
      else $error("pin reset seen while idle");
endmodule
bind smc_system_config smc_sc_chk #(.NPORT(NPORT)) smc_sc_chk_i (.*);

// file: tb_smc_system_config.sv
module tb_smc_system_config;
   timeunit 1ns;
   timeprecision 1ps;
   logic        i_clk_sys, i_nrst, i_fuse_compat, i_fuse_tristate, i_fuse_dbl_speed, i_reset_sense_select;
   logic        i_reset_pin, i_timer0_ovf, i_timer1_ovf, i_fetch_req, i_fetch_external, s_axi_awvalid;
   logic        s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, cap_compat, cap_tri, cap_dbl;
   logic [1:0]  r, pv;
   logic [5:0]  i_ext_pins;
   logic [7:0]  i_keypad_events, s_axi_awaddr, s_axi_araddr;
   logic [15:0] i_fetch_addr;
   logic [31:0] s_axi_wdata, rnd, d;
   logic [31:0] wv [12];
   wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, o_sys_reset, o_timer_tick;
   wire         o_timer2_tick, o_fetch_strobe, o_fetch_allowed, o_double_speed_select, o_address_latch_strobe_off;
   wire         o_onchip_xdata_enable, o_stack_in_extra_ram, o_flash_api_access, o_eeprom_access_enable;
   wire         o_timer0_count_pin, o_timer0_count_pin_oe, o_timer1_count_pin, o_timer1_count_pin_oe;
   wire [1:0]   s_axi_bresp, s_axi_rresp, o_xmem_wait_states;
   wire [3:0]   o_timer_prescale_field;
   wire [5:0]   o_sampled_pins;
   wire [7:0]   o_clock_reload_divider;
   wire [31:0]  s_axi_rdata;
   wire [63:0]  o_pin_modes;
   int          miscompares = 0;
   int          checked = 0;
   int          c;
   localparam logic [7:0]  RA [12] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h30, 8'h20, 8'h24,
      8'h28, 8'h2c};
   localparam logic [31:0] RM [12] = '{32'h0000_00f0, 32'h0000_0063, 32'h0000_0030, 32'h0000_0002,
      32'h0000_0001, 32'h0000_00ff, 32'h0000_0007, 32'h0000_0001, 32'hffff_ffff, 32'hffff_ffff,
      32'h0000_ffff, 32'h0000_0003};
   smc_system_config #(.NPORT(4)) smc_system_config_i (.*, .i_fuse_xdata(1'b1), .s_axi_wstrb(4'hf),
      .o_fast_mode(), .o_exec_unit(), .o_port4_modes(), .o_keypad_flag_reg());
   // ----
   // helpers
   // ----
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic [31:0] dflt(input int i);
      case (i)
         0: return cap_compat ? 32'h0000_0050 : 32'h0000_0000;
         1: return 32'h0000_0002;
         4: return {31'h0, cap_dbl | !cap_compat};
         5: return 32'h0000_00ff;
         8: return cap_tri ? 32'h0000_0000 : 32'h0000_00ff;
         9: return cap_tri ? 32'hffff_ffff : 32'h0000_00ff;
         11: return {30'h0, cap_tri, !cap_compat};
         default: return 32'h0000_0000;
      endcase
   endfunction
   task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] s);
      checked++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge i_clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      forever begin
         @(posedge i_clk_sys);
         if (s_axi_bvalid === 1'b1) begin
            r = s_axi_bresp;
            break;
         end
         if (s_axi_awready === 1'b1)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1)
            s_axi_wvalid <= 1'b0;
      end
   endtask
   task automatic rd(input logic [7:0] a);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      forever begin
         @(posedge i_clk_sys);
         if (s_axi_rvalid === 1'b1) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
         if (s_axi_arready === 1'b1) begin
            s_axi_arvalid <= 1'b0;
         end
      end
   endtask
   task automatic cnt(input int sel, input int n);
      c = 0;
      repeat (n) begin
         @(posedge i_clk_sys);
         c += (sel == 0) ? o_timer_tick : (sel == 1) ? o_timer2_tick : o_fetch_strobe;
      end
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // ----
   // clock, watchdog, tests
   // ----
   initial begin
      i_clk_sys = 1'b0;
      forever #5 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      cyc(50000);
      miscompares++;
      finish_test();
   end
   initial begin
      {i_nrst, i_fuse_tristate, i_fuse_dbl_speed, i_timer0_ovf, i_timer1_ovf, i_fetch_req} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, i_reset_sense_select} = '0;
      {s_axi_bready, s_axi_rready} = 2'h3;
      {i_fetch_external, i_fetch_addr, i_ext_pins, i_keypad_events, s_axi_awaddr, s_axi_araddr} = '0;
      i_fuse_compat = 1'b1;
      i_reset_pin = 1'b1;
      s_axi_wdata = 32'h0000_0000;
      rnd = 32'hc6ba_4906;
      for (int p = 0; p < 2; p++) begin
         i_fuse_compat <= !p[0];
         i_fuse_tristate <= p[0];
         i_fuse_dbl_speed <= p[0];
         i_nrst <= 1'b0;
         cyc(16);
         i_nrst <= 1'b1;
         {cap_compat, cap_tri, cap_dbl} = {i_fuse_compat, i_fuse_tristate, i_fuse_dbl_speed};
         cyc(1);
         // fuses flip after release: captured values must hold
         i_fuse_compat <= p[0];
         i_fuse_tristate <= !p[0];
         i_fuse_dbl_speed <= !p[0];
         for (int i = 0; i < 12; i++) begin
            rd(RA[i]);
            chk("reset value", dflt(i), d & RM[i]);
            rnd = lfsr(rnd);
            wv[i] = rnd;
            wr(RA[i], rnd);
         end
         for (int i = 0; i < 12; i++) begin
            rd(RA[i]);
            chk("readback", (i == 11) ? dflt(11) : wv[i] & RM[i], d & RM[i]);
         end
         chk("prescale", wv[0][7:4], o_timer_prescale_field);
         chk("latch strobe", wv[1][0], o_address_latch_strobe_off);
         chk("xdata", wv[1][1], o_onchip_xdata_enable);
         chk("wait states", wv[1][6:5], o_xmem_wait_states);
         chk("stack", wv[2][4], o_stack_in_extra_ram);
         chk("eeprom", wv[3][1], o_eeprom_access_enable);
         chk("flash api", wv[2][5], o_flash_api_access);
         chk("divider", {wv[4][0], wv[5][7:0]}, {o_double_speed_select, o_clock_reload_divider});
         chk("pin modes", {wv[9][31], wv[8][31], wv[9][0], wv[8][0]}, {o_pin_modes[63:62], o_pin_modes[1:0]});
         wr(8'h34, rnd);
         chk("unmapped write", 2'h2, r);
         rd(8'hfc);
         chk("unmapped read", {2'h2, 32'h0000_0000}, {r, d});
         for (int f = 0; f < 16; f++) begin
            wr(8'h00, {f[3:0], 4'h0});
            wr(8'h30, {31'h0, f[0]});
            cyc(40);
            cnt(0, 4 * (f + 1));
            chk("timer ticks", 4, c);
            cnt(1, 4 * (f + 1));
            chk("timer2 ticks", f[0] ? 4 * (f + 1) : 4, c);
         end
         i_fetch_req <= 1'b1;
         cyc(4);
         cnt(2, 30);
         chk("fetch strobes", cap_compat ? 10 : 30, c);
         for (int k = 0; k < 4; k++) begin
            wr(8'h18, {29'h0, k[1], 2'h0});
            i_fetch_external <= 1'b1;
            i_fetch_addr <= k[0] ? 16'h2000 : 16'h1fff;
            cyc(3);
            chk("fetch allowed", k == 1, o_fetch_allowed);
         end
         {i_fetch_req, i_fetch_external} <= 2'h0;
         wr(8'h18, 32'h0000_0003);
         pv = {o_timer1_count_pin, o_timer0_count_pin};
         {i_keypad_events, i_timer0_ovf, i_timer1_ovf} <= {8'ha5, 2'h3};
         cyc(1);
         {i_keypad_events, i_timer0_ovf, i_timer1_ovf} <= 10'h000;
         cyc(3);
         chk("count pins", {2'h3, pv ^ 2'h3}, {o_timer1_count_pin_oe, o_timer0_count_pin_oe, o_timer1_count_pin,
            o_timer0_count_pin});
         rd(8'h1c);
         rd(8'h1c);
         chk("keypad flags", 8'ha5, d);
         wr(8'h1c, 32'h0000_0004);
         rd(8'h1c);
         chk("keypad clear", 8'ha1, d);
         rnd = lfsr(rnd);
         i_ext_pins <= rnd[5:0];
         cyc(40);
         chk("pin sample", rnd[5:0], o_sampled_pins);
         for (int s = 0; s < 2; s++) begin
            wr(8'h14, 32'h0000_0012);
            i_reset_sense_select <= s[0];
            i_reset_pin <= s[0];
            cyc(14); // longer than the minimum pulse
            chk("pin reset", 1'b1, o_sys_reset);
            i_reset_pin <= !s[0];
            cyc(6);
            chk("pin release", 1'b0, o_sys_reset);
            rd(8'h14);
            chk("divider after pin reset", 8'hff, d);
         end
         $display("test phase %0d done", p);
      end
      finish_test();
   end
endmodule
